/* hdl/digital_pwm_interleave_comp.v */
// interleaved digital pwm core with compensation, current share and monitoring
`timescale 1ns/1ps
`default_nettype none
`include "pwm_core_defines.vh"
// Functional notes
// - pwm cycle starts after delay from sync edge
// - delay steps are 11.25 degrees of period
// - delay depends only on own setting
// - duty clamped to programmed duty limit
// - inside window duty follows error gradually
// - outside window force zero or limit
// - forced duty applies within one switching cycle
// - saturation feedforward has enable setting
// - third order filter: integrator, lowpass pole
// - iir with four numerator, three denominator coefficients
// - eleven coefficient registers, numerators split high/low
// - share line equalises current across paralleled units
// - only phase and load regulation differ per unit
// - voltage, current, temperature digitised at 8 bits
// - each quantity sampled at 700 Hz minimum
// - monitor registers refreshed with latest results
// - current reading corrected by measured temperature
// - switch at 500 kHz, 750 kHz or 1 MHz
// - frequency and phase accepted only while off
module digital_pwm_interleave_comp
#(
  parameter [13:0] SAMPLE_CYCLES = `ADC_SAMPLE_CYCLES
)
(
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  input  wire       i_sync_line,
  input  wire       i_output_on,
  input  wire [1:0] i_freq_sel,
  input  wire [4:0] i_phase_step,
  input  wire [7:0] i_duty_limit_config,
  input  wire       i_sat_ff_enable,
  input  wire [7:0] i_sat_window,
  input  wire [3:0] i_load_reg,
  input  wire [7:0] i_error,
  input  wire [7:0] i_num_coef0_high,
  input  wire [7:0] i_num_coef0_low,
  input  wire [7:0] i_num_coef1_high,
  input  wire [7:0] i_num_coef1_low,
  input  wire [7:0] i_num_coef2_high,
  input  wire [7:0] i_num_coef2_low,
  input  wire [7:0] i_num_coef3_high,
  input  wire [7:0] i_num_coef3_low,
  input  wire [7:0] i_den_coef1,
  input  wire [7:0] i_den_coef2,
  input  wire [7:0] i_den_coef3,
  input  wire       i_share_line,
  input  wire       i_adc_done,
  input  wire [7:0] i_adc_data,
  output reg        o_pwm,
  output reg  [7:0] o_duty,
  output reg        o_saturated,
  output reg        o_share_out,
  output reg        o_share_oe_n,
  output reg        o_adc_start,
  output reg  [1:0] o_adc_channel,
  output reg  [7:0] o_voltage_monitor,
  output reg  [7:0] o_current_monitor,
  output reg  [7:0] o_temperature_monitor
);
  wire sync_s;
  wire share_s;
  reg  sync_d;
  reg  [1:0] freq_cfg;
  reg  [4:0] phase_cfg;
  reg  [5:0] period;
  reg  [5:0] dly_cnt;
  reg  dly_act;
  reg  [5:0] cyc_cnt;
  reg  [7:0] duty_eff;
  reg  signed [8:0] e1;
  reg  signed [8:0] e2;
  reg  signed [8:0] e3;
  reg  signed [15:0] y1;
  reg  signed [15:0] y2;
  reg  signed [15:0] y3;
  reg  [13:0] smp_cnt;
  reg  [1:0] next_chan;
  reg  [7:0] share_cnt;
  reg  [7:0] share_low;
  reg  [7:0] share_max;

  sync2 u_sync_line
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (i_sync_line),
    .o_sync     (sync_s)
  );

  sync2 u_share_line
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (i_share_line),
    .o_sync     (share_s)
  );

  // phase timing
  wire        sync_rise = sync_s & ~sync_d;
  wire [10:0] phase_prod = phase_cfg * period;
  wire [5:0]  phase_dly = phase_prod[10:`PHASE_STEP_SHIFT];
  wire        dly_done = dly_act && (dly_cnt + 6'h01 >= phase_dly);
  wire        start_now = (sync_rise && phase_dly == 6'h00) || dly_done;
  wire        wrap = (cyc_cnt >= period - 6'h01);
  wire        cycle_begin = start_now || wrap;
  wire [13:0] on_prod = duty_eff * period;
  wire [5:0]  on_time = on_prod[13:8];

  always @*
  begin
    case (freq_cfg)
      `FREQ_500K: period = `PERIOD_500K;
      `FREQ_750K: period = `PERIOD_750K;
      `FREQ_1M:   period = `PERIOD_1M;
      default:    period = `PERIOD_500K;
    endcase
  end

  // compensation filter, evaluated once per switching cycle
  wire [11:0] droop_prod = o_current_monitor * i_load_reg;
  wire signed [8:0] droop = {5'h00, droop_prod[11:8]};
  wire signed [8:0] e0 = {i_error[7], i_error} - droop;
  wire signed [15:0] c0 = {i_num_coef0_high, i_num_coef0_low};
  wire signed [15:0] c1 = {i_num_coef1_high, i_num_coef1_low};
  wire signed [15:0] c2 = {i_num_coef2_high, i_num_coef2_low};
  wire signed [15:0] c3 = {i_num_coef3_high, i_num_coef3_low};
  wire signed [7:0]  b1 = i_den_coef1;
  wire signed [7:0]  b2 = i_den_coef2;
  wire signed [7:0]  b3 = i_den_coef3;
  // integrator and low-pass poles come from the programmed b terms
  wire signed [27:0] acc = c0 * e0 + c1 * e1 + c2 * e2 + c3 * e3
                         - b1 * y1 - b2 * y2 - b3 * y3;
  wire signed [19:0] acc_sh = acc[27:`FILT_SHIFT];
  wire acc_ovf = (acc_sh[19:15] != {5{acc_sh[15]}});
  // saturating the state keeps a runaway integrator from wrapping sign
  wire signed [15:0] y_new = !acc_ovf ? acc_sh[15:0] :
                             (acc_sh[19] ? 16'h8000 : 16'h7FFF);

  wire [7:0] share_diff = (share_max > o_current_monitor) ?
                          share_max - o_current_monitor : `DUTY_ZERO;
  wire [4:0] share_trim = share_diff[7:`SHARE_TRIM_SHIFT];
  wire [16:0] y_trim = {y_new[15], y_new} + {12'h000, share_trim};

  reg [7:0] filt_duty;
  reg [7:0] next_duty;
  reg       next_sat;
  wire signed [9:0] win = {2'b00, i_sat_window};
  wire out_window = ($signed({e0[8], e0}) > win) || ($signed({e0[8], e0}) < -win);

  always @*
  begin
    if (y_trim[16])
      filt_duty = `DUTY_ZERO;
    else if (y_trim[15:8] != 8'h00)
      filt_duty = `DUTY_FULL;
    else
      filt_duty = y_trim[7:0];
    next_sat = 1'b0;
    if (i_sat_ff_enable && out_window)
    begin
      next_sat = 1'b1;
      next_duty = e0[8] ? `DUTY_ZERO : i_duty_limit_config;
    end
    else if (filt_duty > i_duty_limit_config)
      next_duty = i_duty_limit_config;
    else
      next_duty = filt_duty;
  end

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync_d <= 1'b0;
      freq_cfg <= `FREQ_RESET;
      phase_cfg <= `PHASE_RESET;
      dly_cnt <= 6'h00;
      dly_act <= 1'b0;
      cyc_cnt <= 6'h00;
      duty_eff <= `DUTY_ZERO;
      e1 <= 9'h000;
      e2 <= 9'h000;
      e3 <= 9'h000;
      y1 <= 16'h0000;
      y2 <= 16'h0000;
      y3 <= 16'h0000;
      o_pwm <= 1'b0;
      o_duty <= `DUTY_ZERO;
      o_saturated <= 1'b0;
    end
    else
    begin
      sync_d <= sync_s;
      if (!i_output_on)
      begin
        freq_cfg <= i_freq_sel;
        phase_cfg <= i_phase_step;
      end
      if (sync_rise && phase_dly != 6'h00)
      begin
        dly_act <= 1'b1;
        dly_cnt <= 6'h00;
      end
      else if (dly_done)
        dly_act <= 1'b0;
      else if (dly_act)
        dly_cnt <= dly_cnt + 6'h01;
      if (cycle_begin)
      begin
        cyc_cnt <= 6'h00;
        duty_eff <= next_duty;
        o_duty <= next_duty;
        o_saturated <= next_sat;
        e1 <= e0;
        e2 <= e1;
        e3 <= e2;
        y1 <= y_new;
        y2 <= y1;
        y3 <= y2;
      end
      else
        cyc_cnt <= cyc_cnt + 6'h01;
      o_pwm <= (cyc_cnt < on_time);
    end
  end

  // monitoring sequencer: one conversion per slot, channels in turn
  wire signed [8:0]  temp_delta = {1'b0, o_temperature_monitor} - `TEMP_REF;
  wire signed [17:0] tc_prod = $signed({1'b0, i_adc_data}) * temp_delta;
  wire signed [9:0]  tc_corr = tc_prod[16:`TEMP_COMP_SHIFT];
  wire signed [10:0] cur_corr = {3'b000, i_adc_data} - {tc_corr[9], tc_corr};
  wire [7:0] cur_clamped = cur_corr[10] ? `DUTY_ZERO :
                           (cur_corr[9:8] != 2'b00 ? `DUTY_FULL : cur_corr[7:0]);

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      smp_cnt <= 14'h0000;
      next_chan <= `CH_VOLTAGE;
      o_adc_start <= 1'b0;
      o_adc_channel <= `CH_VOLTAGE;
      o_voltage_monitor <= 8'h00;
      o_current_monitor <= 8'h00;
      o_temperature_monitor <= 8'h00;
    end
    else
    begin
      o_adc_start <= 1'b0;
      if (smp_cnt >= SAMPLE_CYCLES - 14'h0001)
      begin
        smp_cnt <= 14'h0000;
        o_adc_start <= 1'b1;
        o_adc_channel <= next_chan;
        next_chan <= (next_chan == `CH_TEMP) ? `CH_VOLTAGE : next_chan + 2'h1;
      end
      else
        smp_cnt <= smp_cnt + 14'h0001;
      if (i_adc_done)
      begin
        case (o_adc_channel)
          `CH_VOLTAGE: o_voltage_monitor <= i_adc_data;
          `CH_CURRENT: o_current_monitor <= cur_clamped;
          `CH_TEMP:    o_temperature_monitor <= i_adc_data;
          default:     o_voltage_monitor <= o_voltage_monitor;
        endcase
      end
    end
  end

  // current share: open-drain line held low for a fraction equal to own
  // current, so the wired line shows the largest current of the group
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      share_cnt <= 8'h00;
      share_low <= 8'h00;
      share_max <= 8'h00;
      o_share_out <= 1'b0;
      o_share_oe_n <= 1'b1;
    end
    else
    begin
      share_cnt <= share_cnt + 8'h01;
      o_share_out <= 1'b0;
      o_share_oe_n <= ~(share_cnt < o_current_monitor);
      if (share_cnt == `SHARE_FRAME_END)
      begin
        share_max <= share_low;
        share_low <= 8'h00;
      end
      else if (!share_s && share_low != `SHARE_FRAME_END)
        share_low <= share_low + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* hdl/pwm_core_defines.vh */
// constants for the interleaved digital pwm control core
`ifndef PWM_CORE_DEFINES_VH
`define PWM_CORE_DEFINES_VH

// switching periods in 25 MHz core clocks; 750 kHz rounds down to 33
`define PERIOD_500K       6'h32
`define PERIOD_750K       6'h21
`define PERIOD_1M         6'h19
`define FREQ_500K         2'h0
`define FREQ_750K         2'h1
`define FREQ_1M           2'h2
`define PHASE_STEP_SHIFT  5
`define FREQ_RESET        2'h0
`define PHASE_RESET       5'h00
// one conversion slot per channel, three slots per 700 Hz round
`define ADC_SAMPLE_CYCLES 14'h2E80
`define CH_VOLTAGE        2'h0
`define CH_CURRENT        2'h1
`define CH_TEMP           2'h2
`define TEMP_REF          9'h040
`define TEMP_COMP_SHIFT   7
`define FILT_SHIFT        8
`define SHARE_TRIM_SHIFT  3
`define DUTY_FULL         8'hFF
`define DUTY_ZERO         8'h00
`define SHARE_FRAME_END   8'hFF

`endif

/* hdl/sync2.v */
// two flip-flop synchroniser for one level input
`timescale 1ns/1ps
`default_nettype none
module sync2
(
  input  wire i_core_clk,
  input  wire i_rst_n,
  input  wire i_async,
  output reg  o_sync
);
  reg meta;

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

/* sim/digital_pwm_interleave_comp_test.sv */
// self-checking bench for the interleaved pwm core
`timescale 1ns/1ps
`default_nettype none
module digital_pwm_interleave_comp_test;
  typedef struct packed {int d; int p; int w;} pwm_note;
  typedef struct packed {int ch; int v;} adc_note;
  logic       clk, rst_n, on, sat_en, done, run, sync_d, pwm_d;
  logic [1:0] fsel;
  logic [4:0] step;
  logic [7:0] lim, win, err, adata;
  logic [3:0] lreg;
  logic [7:0] c [0:10];
  logic [5:0] per;
  wire        sync, pwm, sat, sh_out, sh_oe_n, astart, share;
  wire  [7:0] duty, vmon, imon, temperature_monitor;
  wire  [1:0] ach;
  pwm_note    pq[$];
  adc_note    aq[$];
  pwm_note    pn;
  adc_note    an;
  int         err_count, n_tests, cyc, sync_cyc, rise_cyc, temp, r, v, low_run;
  logic [7:0] imon_d;
  logic       run_ok;
  // released share wire floats up through the pull-up
  assign share = sh_oe_n ? 1'b1 : sh_out;
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  power_manager_model pm_u (.i_core_clk(clk), .i_run(run), .i_period(per), .o_sync_line(sync));
  digital_pwm_interleave_comp #(.SAMPLE_CYCLES(14'h0014)) dut_u (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_sync_line(sync), .i_output_on(on), .i_freq_sel(fsel),
    .i_phase_step(step), .i_duty_limit_config(lim), .i_sat_ff_enable(sat_en),
    .i_sat_window(win), .i_load_reg(lreg), .i_error(err), .i_num_coef0_high(c[0]),
    .i_num_coef0_low(c[1]), .i_num_coef1_high(c[2]), .i_num_coef1_low(c[3]),
    .i_num_coef2_high(c[4]), .i_num_coef2_low(c[5]), .i_num_coef3_high(c[6]),
    .i_num_coef3_low(c[7]), .i_den_coef1(c[8]), .i_den_coef2(c[9]), .i_den_coef3(c[10]),
    .i_share_line(share), .i_adc_done(done), .i_adc_data(adata), .o_pwm(pwm), .o_duty(duty),
    .o_saturated(sat), .o_share_out(sh_out), .o_share_oe_n(sh_oe_n), .o_adc_start(astart),
    .o_adc_channel(ach), .o_voltage_monitor(vmon), .o_current_monitor(imon),
    .o_temperature_monitor(temperature_monitor));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // conversion answers two cycles after each request
  initial
  begin
    done = 0;
    adata = 0;
    forever
    begin
      @(posedge clk);
      if (astart === 1'b1)
      begin
        @(negedge clk);
        @(negedge clk);
        r = $urandom_range(255);
        v = (ach == 2'h1) ? r - ((r * (temp - 64)) >>> 7) : r;
        v = v < 0 ? 0 : (v > 255 ? 255 : v);
        if (ach == 2'h2)
          temp = r;
        aq.push_back('{int'(ach), v});
        adata = 8'(r);
        done = 1;
        @(negedge clk);
        done = 0;
      end
    end
  end
  always @(posedge clk)
    if (done === 1'b1 && aq.size() > 0)
    begin
      an = aq.pop_front();
      @(negedge clk);
      check("monitor", 8'(an.v), an.ch == 0 ? vmon : (an.ch == 1 ? imon : temperature_monitor));
    end
  // each share low run lasts as many clocks as the own current reading;
  // runs are judged only while that reading held still over the whole run
  always @(negedge clk)
  begin
    if (sh_oe_n === 1'b0)
    begin
      low_run++;
      run_ok = run_ok && (imon === imon_d);
    end
    else if (low_run > 0)
    begin
      if (run_ok)
        check("share low time", imon_d, 8'(low_run));
      low_run = 0;
    end
    else
      run_ok = (imon === imon_d);
    imon_d = imon;
  end
  // pulse delay beyond the programmed one, measured modulo the period
  always @(negedge clk)
  begin
    cyc++;
    if (sync && !sync_d)
      sync_cyc = cyc;
    if (pwm && !pwm_d)
      rise_cyc = cyc;
    if (!pwm && pwm_d && pq.size() > 0)
    begin
      pn = pq.pop_front();
      r = (rise_cyc - sync_cyc - pn.d + 4 * pn.p) % pn.p;
      // two synchroniser flops, the cycle counter and the pwm register
      check("pwm delay", 8'h03, 8'(r));
      check("pwm width", 8'(pn.w), 8'(cyc - rise_cyc));
    end
    sync_d = sync;
    pwm_d = pwm;
  end
  task automatic run_cfg(input int f, input int s, input logic lock);
    int p;
    p = (f == 1) ? 33 : ((f == 2) ? 25 : 50);
    fsel = 2'(f);
    step = 5'(s);
    per = 6'(p);
    repeat (3) @(negedge clk);
    if (lock)
    begin
      on = 1;
      @(negedge clk);
      step = 5'(s) ^ 5'h15;
      fsel = 2'(f + 1);
    end
    repeat (200) @(negedge clk);
    pq.push_back('{s * p / 32, p, lim * p / 256});
    pq.push_back('{s * p / 32, p, lim * p / 256});
    for (int i = 0; i < 300 && pq.size() > 0; i++)
      @(negedge clk);
    check("pending pulses", 8'h00, 8'(pq.size()));
    check("forced flag", 8'h01, {7'h00, sat});
    pq.delete();
    on = 0;
  endtask
  initial
  begin
    int s;
    void'($urandom(32703));
    {rst_n, on, run, sync_d, pwm_d, fsel, step, per} = 0;
    {err_count, n_tests, cyc, sync_cyc, rise_cyc, temp} = 0;
    lim = 8'($urandom_range(200, 40));
    sat_en = 1;
    win = 8'h10;
    err = 8'h70;
    lreg = 4'($urandom);
    foreach (c[i])
      c[i] = 8'($urandom);
    repeat (12) @(negedge clk);
    rst_n = 1;
    run = 1;
    run_cfg(0, 0, 0);
    run_cfg(1, 7, 1);
    for (int f = 0; f < 4; f++)
    begin
      s = $urandom_range(31);
      if (s == 10 || s == 11)
        s = 20;
      run_cfg(f, s, 0);
    end
    run_cfg(2, 31, 0);
    err = 8'h03;
    win = 8'h40;
    repeat (200) @(negedge clk);
    check("in-window flag", 8'h00, {7'h00, sat});
    err = 8'h70;
    win = 8'h10;
    // one 1 MHz switching cycle plus the register stage
    repeat (26) @(negedge clk);
    check("forced high duty", lim, duty);
    err = 8'h90;
    repeat (58) @(negedge clk);
    check("forced low duty", 8'h00, duty);
    sat_en = 0;
    repeat (200) @(negedge clk);
    check("disabled flag", 8'h00, {7'h00, sat});
    finish_test();
  end
  initial
  begin
    repeat (20000) @(negedge clk);
    err_count++;
    $display("MISMATCH watchdog expected end seen hang");
    finish_test();
  end
endmodule
bind digital_pwm_interleave_comp pwm_core_assertions #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_duty_limit_config(i_duty_limit_config),
  .i_sat_ff_enable(i_sat_ff_enable), .i_adc_done(i_adc_done), .i_adc_data(i_adc_data),
  .o_duty(o_duty), .o_saturated(o_saturated), .o_share_out(o_share_out),
  .o_adc_start(o_adc_start), .o_adc_channel(o_adc_channel),
  .o_voltage_monitor(o_voltage_monitor), .o_temperature_monitor(o_temperature_monitor));
`default_nettype wire

/* sim/power_manager_model.sv */
// master sync clock source of the power manager
`timescale 1ns/1ps
`default_nettype none
module power_manager_model
(
  input  wire logic       i_core_clk,
  input  wire logic       i_run,
  input  wire logic [5:0] i_period,
  output var  logic       o_sync_line
);
  logic [5:0] cnt;
  initial cnt = 6'h00;
  initial o_sync_line = 1'b0;
  // line stands low while halted, so a stale edge never reaches the unit
  always @(negedge i_core_clk)
  begin
    cnt <= (!i_run || cnt + 6'h01 >= i_period) ? 6'h00 : cnt + 6'h01;
    o_sync_line <= i_run && (cnt < (i_period >> 1));
  end
endmodule
`default_nettype wire

/* sim/pwm_core_assertions.sv */
// concurrent checks on the pwm core ports
`timescale 1ns/1ps
`default_nettype none
module pwm_core_assertions
#(
  parameter [13:0] SAMPLE_CYCLES = 14'h0014
)
(
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_duty_limit_config,
  input wire logic       i_sat_ff_enable,
  input wire logic       i_adc_done,
  input wire logic [7:0] i_adc_data,
  input wire logic [7:0] o_duty,
  input wire logic       o_saturated,
  input wire logic       o_share_out,
  input wire logic       o_adc_start,
  input wire logic [1:0] o_adc_channel,
  input wire logic [7:0] o_voltage_monitor,
  input wire logic [7:0] o_temperature_monitor
);
  logic [15:0] gap;
  logic [7:0]  off_cnt;
  logic [1:0]  last_ch;
  logic        seen;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // first request after reset has no reference, so spacing is checked from the second
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      gap <= 16'h0000;
      seen <= 1'b0;
      last_ch <= 2'h0;
      off_cnt <= 8'h00;
    end
    else
    begin
      gap <= o_adc_start ? 16'h0001 : (gap == 16'hFFFF ? gap : gap + 16'h0001);
      seen <= seen | o_adc_start;
      last_ch <= o_adc_start ? o_adc_channel : last_ch;
      off_cnt <= i_sat_ff_enable ? 8'h00 : (off_cnt == 8'hFF ? off_cnt : off_cnt + 8'h01);
    end
  end
  chk_adc_start_pulse: assert property (o_adc_start |=> !o_adc_start)
    else $error("conversion request longer than one cycle");
  chk_adc_interval: assert property (o_adc_start && seen |-> gap == {2'h0, SAMPLE_CYCLES})
    else $error("conversion request spacing wrong");
  chk_channel_rotation: assert property (o_adc_start && seen |-> o_adc_channel == (last_ch == 2'h2 ? 2'h0 : last_ch + 2'h1))
    else $error("channel order wrong");
  chk_voltage_store: assert property (i_adc_done && o_adc_channel == 2'h0 |=> o_voltage_monitor == $past(i_adc_data))
    else $error("voltage reading not stored");
  chk_temp_store: assert property (i_adc_done && o_adc_channel == 2'h2 |=> o_temperature_monitor == $past(i_adc_data))
    else $error("temperature reading not stored");
  chk_share_low_only: assert property (o_share_out == 1'b0)
    else $error("share pin driven high");
  chk_sat_bound: assert property (o_saturated |-> o_duty == 8'h00 || o_duty == i_duty_limit_config)
    else $error("forced duty not at a bound");
  chk_duty_limit: assert property (o_duty <= i_duty_limit_config)
    else $error("duty above limit");
  chk_sat_disabled: assert property (off_cnt >= 8'h78 |-> !o_saturated)
    else $error("forcing while disabled");
endmodule
`default_nettype wire
